// ==== inc/sbc_pkg.sv ====
// constants and types for the supervisory pin control block
package sbc_pkg;
    localparam int CLK_MHZ = 100;
    // interrupt pulse lengths in microseconds, selected by pulse_long
    localparam int INT_PULSE_SHORT_US = 25;
    localparam int INT_PULSE_LONG_US = 100;
    localparam int INT_PULSE_SHORT_CYC = INT_PULSE_SHORT_US * CLK_MHZ;
    localparam int INT_PULSE_LONG_CYC = INT_PULSE_LONG_US * CLK_MHZ;
    // reset line sense must disagree this long before a fault is flagged
    localparam int RST_SENSE_US = 10;
    localparam int RST_SENSE_CYC = RST_SENSE_US * CLK_MHZ;
    localparam int CNT_W = 14;
    localparam logic [2:0] MUX_RESET = 3'h0;
    localparam logic [2:0] MUX_LAST = 3'h6;
    localparam logic [1:0] IO_INPUT = 2'h0;
    localparam logic [1:0] IO_HIGH_SIDE = 2'h1;
    localparam logic [1:0] IO_LOW_SIDE = 2'h2;
    localparam logic [1:0] IO_HIGH_Z = 2'h3;
    localparam logic [1:0] SAFE_CODE_RESET = 2'h0;

    typedef enum logic [1:0] {
        SBC_DBG_OFF = 2'b00,
        SBC_DBG_ON = 2'b01,
        SBC_DBG_DONE = 2'b10
    } sbc_dbg_e;
endpackage

// ==== core/sbc_supervisory_pin_control.sv ====
// supervisory control: aux regulator, undervoltage, io, mux, debug, safe
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
//
// Contract
// - aux regulator off after reset; only host writes switch it on
// - aux regulator level selects 5.0 V or 3.3 V by host setting
// - aux undervoltage or overcurrent turns it off, flags, may interrupt
// - upper undervoltage crossing yields reset or interrupt, host chooses
// - lower threshold option, in normal mode only: interrupt at upper, reset only at lower
// - undervoltage reset stays active in low power supply on mode
// - reset line level monitored; stuck line flags a fault
// - io pins inputs at reset; host sets high side, low side, high-z
// - low power holds io state unless cyclic sense is on; io overload protection off there
// - cyclic sense: pin 0 drives, pins 1 to 3 are wake inputs
// - analog output source is one of seven host-selected signals
// - internal current load resistor connected by host setting
// - mux selection writes ignored while transceiver supply is off
// - debug window sampled on leaving init reset enters debug mode
// - debug mode needs no watchdog refresh; debug flag readable
// - leaving the debug window ends debug and restores watchdog
// - host exit command ends debug even with debug voltage present
// - safe mode from resistor code unless overridden; not in debug
// - safe output driven low whenever a fault event is detected
// - interrupt line holds low or pulses low; host picks style, length
module sbc_supervisory_pin_control (
    input wire logic clk,
    input wire logic reset_n,
    // host configuration writes
    input wire logic aux_on_wr,
    input wire logic aux_off_wr,
    input wire logic aux_sel_3v3,
    input wire logic uv_upper_is_int,
    input wire logic uv_lower_sel,
    input wire logic io_cfg_wr,
    input wire logic [7:0] io_cfg,
    input wire logic cyclic_sense_en,
    input wire logic mux_sel_wr,
    input wire logic [2:0] mux_sel,
    input wire logic load_res_en,
    input wire logic debug_exit_wr,
    input wire logic safe_ovr_en,
    input wire logic [1:0] safe_ovr_code,
    input wire logic int_pulse_mode,
    input wire logic pulse_long,
    input wire logic aux_int_en,
    input wire logic flag_clr,
    // mode inputs from the mode state machine
    input wire logic normal_mode,
    input wire logic low_power_mode,
    input wire logic low_power_supply_on_mode,
    input wire logic init_reset_exit,
    input wire logic transceiver_supply_on,
    input wire logic fault_event,
    input wire logic [1:0] safe_res_code,
    // analog comparator pins
    input wire logic aux_uv_cmp,
    input wire logic aux_oc_cmp,
    input wire logic uv_upper_cmp,
    input wire logic uv_lower_cmp,
    input wire logic debug_window_cmp,
    input wire logic reset_line_sense,
    input wire logic [3:0] io_pin_in,
    // outputs
    output logic aux_regulator_en,
    output logic aux_regulator_3v3,
    output logic aux_fault_flag,
    output logic reset_req,
    output logic reset_line_fault,
    output logic [7:0] io_mode,
    output logic io_protect_en,
    output logic [3:0] wake_in,
    output logic [2:0] analog_select,
    output logic load_res_on,
    output logic debug_mode,
    output logic watchdog_en,
    output logic [1:0] safe_mode_code,
    output logic fail_safe_out_n,
    output logic interrupt_out_n
);
    import sbc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // comparator synchronisers
    logic [9:0] cmp_meta_r;
    logic [9:0] cmp_r;
    logic aux_uv_s, aux_oc_s, uv_up_s, uv_lo_s, dbg_win_s, rst_sense_s;
    logic [3:0] io_in_s;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cmp_meta_r <= 10'h000;
            cmp_r <= 10'h000;
        end else begin
            cmp_meta_r <= {io_pin_in, reset_line_sense, debug_window_cmp,
                uv_lower_cmp, uv_upper_cmp, aux_oc_cmp, aux_uv_cmp};
            cmp_r <= cmp_meta_r;
        end
    end
    assign {io_in_s, rst_sense_s, dbg_win_s, uv_lo_s, uv_up_s,
        aux_oc_s, aux_uv_s} = cmp_r;

    ////////////////////////////////////////////////////////////////////////
    // aux regulator
    logic aux_trip;
    assign aux_trip = aux_regulator_en && (aux_uv_s || aux_oc_s);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            aux_regulator_en <= 1'b0;
        end else if (aux_trip) begin
            aux_regulator_en <= 1'b0;
        end else if (aux_on_wr) begin
            aux_regulator_en <= 1'b1;
        end else if (aux_off_wr) begin
            aux_regulator_en <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            aux_regulator_3v3 <= 1'b0;
        end else begin
            aux_regulator_3v3 <= aux_sel_3v3;
        end
    end

    // set wins over clear so a trip in the clear cycle is kept
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            aux_fault_flag <= 1'b0;
        end else if (aux_trip) begin
            aux_fault_flag <= 1'b1;
        end else if (flag_clr) begin
            aux_fault_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // undervoltage reset or interrupt
    logic uv_up_d_r;
    logic uv_int_evt;
    logic uv_reset;
    logic lower_active;
    assign lower_active = uv_lower_sel && normal_mode;
    // upper crossing interrupts when chosen, or under lower threshold option in normal mode
    assign uv_int_evt = uv_up_s && !uv_up_d_r &&
        (uv_upper_is_int || lower_active);
    // monitoring is not gated by low power supply on mode
    assign uv_reset = lower_active ? uv_lo_s :
        (uv_up_s && !uv_upper_is_int);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            uv_up_d_r <= 1'b0;
            reset_req <= 1'b0;
        end else begin
            uv_up_d_r <= uv_up_s;
            reset_req <= uv_reset;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reset line sense: compare sensed level with driven level
    logic [CNT_W-1:0] rst_cnt_r;
    logic rst_mismatch;
    assign rst_mismatch = rst_sense_s == reset_req;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rst_cnt_r <= '0;
        end else if (!rst_mismatch) begin
            rst_cnt_r <= '0;
        end else if (rst_cnt_r != CNT_W'(RST_SENSE_CYC)) begin
            rst_cnt_r <= rst_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            reset_line_fault <= 1'b0;
        end else if (rst_cnt_r == CNT_W'(RST_SENSE_CYC)) begin
            reset_line_fault <= 1'b1;
        end else if (flag_clr) begin
            reset_line_fault <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configurable io
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            io_mode <= {4{IO_INPUT}};
        end else if (cyclic_sense_en) begin
            // pin 0 keeps its driver setting, others become inputs
            io_mode <= {{3{IO_INPUT}}, io_mode[1:0]};
        end else if (io_cfg_wr && !low_power_mode) begin
            io_mode <= io_cfg;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            io_protect_en <= 1'b1;
            wake_in <= 4'h0;
        end else begin
            io_protect_en <= !low_power_mode;
            wake_in <= cyclic_sense_en ? {io_in_s[3:1], 1'b0}
                : io_in_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // analog monitor select
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            analog_select <= MUX_RESET;
        end else if (mux_sel_wr && transceiver_supply_on
            && mux_sel <= MUX_LAST) begin
            analog_select <= mux_sel;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            load_res_on <= 1'b0;
        end else begin
            load_res_on <= load_res_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // debug mode; once left it is not re-entered until reset
    sbc_dbg_e dbg_r;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dbg_r <= SBC_DBG_OFF;
        end else begin
            unique case (dbg_r)
                SBC_DBG_OFF: begin
                    if (init_reset_exit && dbg_win_s) begin
                        dbg_r <= SBC_DBG_ON;
                    end else if (init_reset_exit) begin
                        dbg_r <= SBC_DBG_DONE;
                    end
                end
                SBC_DBG_ON: begin
                    if (debug_exit_wr || !dbg_win_s) begin
                        dbg_r <= SBC_DBG_DONE;
                    end
                end
                SBC_DBG_DONE: dbg_r <= SBC_DBG_DONE;
                default: dbg_r <= SBC_DBG_DONE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            debug_mode <= 1'b0;
            watchdog_en <= 1'b1;
        end else begin
            debug_mode <= dbg_r == SBC_DBG_ON;
            watchdog_en <= dbg_r != SBC_DBG_ON;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fail-safe selection and output
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            safe_mode_code <= SAFE_CODE_RESET;
        end else if (safe_ovr_en) begin
            safe_mode_code <= safe_ovr_code;
        end else if (dbg_r != SBC_DBG_ON) begin
            safe_mode_code <= safe_res_code;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            fail_safe_out_n <= 1'b1;
        end else if (fault_event) begin
            fail_safe_out_n <= 1'b0;
        end else if (flag_clr) begin
            fail_safe_out_n <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt output, level or pulse
    logic int_evt;
    logic int_level_r;
    logic [CNT_W-1:0] pulse_cnt_r;
    assign int_evt = (aux_trip && aux_int_en) || uv_int_evt;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            int_level_r <= 1'b0;
        end else if (int_evt) begin
            int_level_r <= 1'b1;
        end else if (flag_clr) begin
            int_level_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pulse_cnt_r <= '0;
        end else if (int_evt) begin
            pulse_cnt_r <= pulse_long ? CNT_W'(INT_PULSE_LONG_CYC)
                : CNT_W'(INT_PULSE_SHORT_CYC);
        end else if (pulse_cnt_r != '0) begin
            pulse_cnt_r <= pulse_cnt_r - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            interrupt_out_n <= 1'b1;
        end else if (int_pulse_mode) begin
            interrupt_out_n <= !(int_evt || pulse_cnt_r > 1);
        end else begin
            interrupt_out_n <= !(int_evt || int_level_r);
        end
    end
endmodule

`default_nettype wire

// ==== bench/sbc_supervisory_checker.sv ====
// concurrent checks on the supervisory pin control ports
`timescale 1ns/1ps
`default_nettype none
module sbc_supervisory_checker (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic aux_on_wr,
    input wire logic aux_uv_cmp,
    input wire logic aux_oc_cmp,
    input wire logic uv_upper_is_int,
    input wire logic uv_lower_sel,
    input wire logic normal_mode,
    input wire logic uv_upper_cmp,
    input wire logic uv_lower_cmp,
    input wire logic mux_sel_wr,
    input wire logic transceiver_supply_on,
    input wire logic debug_exit_wr,
    input wire logic debug_window_cmp,
    input wire logic fault_event,
    input wire logic aux_regulator_en,
    input wire logic aux_fault_flag,
    input wire logic reset_req,
    input wire logic [2:0] analog_select,
    input wire logic debug_mode,
    input wire logic watchdog_en,
    input wire logic fail_safe_out_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    chk_aux_on_cause: assert property (
        $rose(aux_regulator_en) |-> $past(aux_on_wr)
    ) else $error("aux regulator on without write");
    // four samples cover the two sync stages plus the register
    chk_aux_trip_off: assert property (
        aux_regulator_en && (aux_uv_cmp || aux_oc_cmp)
            ##1 (aux_uv_cmp || aux_oc_cmp) [*3]
            |-> !aux_regulator_en && aux_fault_flag
    ) else $error("aux fault did not trip");
    chk_uv_upper_rst: assert property (
        (uv_upper_cmp && !uv_upper_is_int && !uv_lower_sel) [*4] |-> reset_req
    ) else $error("upper undervoltage gave no reset");
    chk_uv_lower_only: assert property (
        (uv_lower_sel && normal_mode && !uv_lower_cmp) [*4] |-> !reset_req
    ) else $error("reset above lower threshold");
    chk_mux_refuse: assert property (
        mux_sel_wr && !transceiver_supply_on |=> $stable(analog_select)
    ) else $error("mux select taken with supply off");
    chk_dbg_exit_cmd: assert property (
        debug_exit_wr |-> ##[1:2] !debug_mode
    ) else $error("debug exit command ignored");
    // five samples: two sync stages, the state, then the flag register
    chk_dbg_window_off: assert property (
        !debug_window_cmp [*5] |-> !debug_mode
    ) else $error("debug kept without window");
    chk_dbg_no_wdog: assert property (
        debug_mode |-> !watchdog_en
    ) else $error("watchdog active in debug");
    chk_safe_on_fault: assert property (
        fault_event |-> ##[1:2] !fail_safe_out_n
    ) else $error("safe output not low on fault");
endmodule
bind sbc_supervisory_pin_control sbc_supervisory_checker i_chk (.*);
`default_nettype wire

// ==== bench/sbc_host_model.sv ====
// host side: pulled-up reset line and analog select settling wait
`timescale 1ns/1ps
`default_nettype none
module sbc_host_model #(
    parameter int SETTLE_CYC = 20
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic reset_req,
    input wire logic line_stuck,
    input wire logic transceiver_supply_on,
    output logic reset_line_sense,
    output logic mux_ok
);
    int cnt;
    // pull-up: line reads low only when driven or shorted to ground
    assign reset_line_sense = !(reset_req || line_stuck);
    always_ff @(posedge clk) begin
        if (!reset_n || !transceiver_supply_on) begin
            cnt <= 0;
        end else if (cnt < SETTLE_CYC) begin
            cnt <= cnt + 1;
        end
    end
    // select only once supply is seen up and its capacitor has charged
    assign mux_ok = transceiver_supply_on && cnt == SETTLE_CYC;
endmodule
`default_nettype wire

// ==== bench/test_sbc_supervisory_pin_control.sv ====
// self-checking bench for the supervisory pin control block
`timescale 1ns/1ps
`default_nettype none
module test_sbc_supervisory_pin_control;
    import sbc_pkg::*;
    bit clk, reset_n, aux_on_wr, aux_off_wr, aux_sel_3v3, uv_upper_is_int;
    bit uv_lower_sel, io_cfg_wr, cyclic_sense_en, mux_sel_wr, load_res_en;
    bit debug_exit_wr, safe_ovr_en, int_pulse_mode, pulse_long, aux_int_en;
    bit flag_clr, normal_mode, low_power_mode, low_power_supply_on_mode;
    bit init_reset_exit, transceiver_supply_on, fault_event, aux_uv_cmp;
    bit aux_oc_cmp, uv_upper_cmp, uv_lower_cmp, debug_window_cmp, line_stuck;
    bit [7:0] io_cfg;
    bit [2:0] mux_sel;
    bit [1:0] safe_ovr_code, safe_res_code;
    bit [3:0] io_pin_in;
    logic aux_regulator_en, aux_regulator_3v3, aux_fault_flag, reset_req;
    logic reset_line_fault, io_protect_en, load_res_on, debug_mode, mux_ok;
    logic watchdog_en, fail_safe_out_n, interrupt_out_n, reset_line_sense;
    logic [7:0] io_mode, exp_io;
    logic [2:0] analog_select;
    logic [1:0] safe_mode_code, es;
    logic [3:0] wake_in;
    logic [31:0] seed = 32'h0000b93b;
    logic [31:0] r;
    int n_mismatch, comparisons;
    sbc_supervisory_pin_control i_dut (.*);
    sbc_host_model i_host (.*);
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function logic [1:0] exp_safe(logic o, logic [1:0] oc, logic [1:0] rc);
        return o ? oc : rc;
    endfunction
    task w(int n);
        repeat (n) @(posedge clk);
    endtask
    // step past the edge so its updates have landed before sampling
    task sk(int n);
        w(n);
        #1;
    endtask
    task chk(string nm, logic [7:0] e, logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task complete_run();
        $display("compares %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        forever #5 clk = ~clk;
    end
////////////////////////////////////////////////////////////////////////////
    initial begin
        w(2);
        reset_n <= 1;
        sk(2);
        chk("aux_en", 0, aux_regulator_en);
        chk("io_mode", 0, io_mode);
        w(1);
        r = rnd();
        aux_on_wr <= 1;
        aux_sel_3v3 <= r[0];
        aux_int_en <= 1;
        w(1);
        aux_on_wr <= 0;
        sk(1);
        chk("aux_en", 1, aux_regulator_en);
        chk("aux_3v3", r[0], aux_regulator_3v3);
        w(1);
        aux_oc_cmp <= 1;
        sk(6);
        chk("aux_trip", 3'b100, {aux_fault_flag, aux_regulator_en,
            interrupt_out_n});
        w(1);
        aux_oc_cmp <= 0;
        w(4);
        flag_clr <= 1;
        w(1);
        flag_clr <= 0;
        sk(1);
        chk("aux_clr", 2'b01, {aux_fault_flag, interrupt_out_n});
        w(1);
        uv_upper_is_int <= 1;
        int_pulse_mode <= 1;
        pulse_long <= 1;
        uv_upper_cmp <= 1;
        sk(6);
        chk("uv_int", 2'b00, {reset_req, interrupt_out_n});
        w(INT_PULSE_LONG_CYC + 8);
        uv_upper_is_int <= 0;
        sk(6);
        chk("uv_rst", 2'b11, {reset_req, interrupt_out_n});
        w(1);
        normal_mode <= 1;
        uv_lower_sel <= 1;
        sk(6);
        chk("uv_low", 0, reset_req);
        w(1);
        uv_lower_cmp <= 1;
        sk(6);
        chk("uv_low", 1, reset_req);
        w(1);
        normal_mode <= 0;
        low_power_supply_on_mode <= 1;
        uv_lower_cmp <= 0;
        sk(6);
        chk("uv_lp", 1, reset_req);
        w(1);
        uv_upper_cmp <= 0;
        low_power_supply_on_mode <= 0;
        exp_io = 8'h00;
        for (int i = 0; i < 8; i++) begin
            w(1);
            r = rnd();
            io_cfg <= r[7:0];
            io_pin_in <= r[11:8];
            low_power_mode <= r[12];
            cyclic_sense_en <= r[13] & r[14];
            io_cfg_wr <= 1;
            w(1);
            io_cfg_wr <= 0;
            sk(1);
            // cyclic sense keeps only the pin 0 driver setting
            if (r[13] & r[14]) exp_io = {6'h00, exp_io[1:0]};
            else if (!r[12]) exp_io = r[7:0];
            chk("io_mode", exp_io, io_mode);
            chk("protect", !r[12], io_protect_en);
            // pin levels need the two sync stages and the output register
            sk(2);
            chk("wake", (r[13] & r[14]) ? {r[11:9], 1'b0} : r[11:8],
                wake_in);
        end
        w(1);
        low_power_mode <= 0;
        cyclic_sense_en <= 0;
        mux_sel <= 3'h5;
        mux_sel_wr <= 1;
        w(1);
        mux_sel_wr <= 0;
        transceiver_supply_on <= 1;
        sk(1);
        chk("mux", MUX_RESET, analog_select);
        for (int i = 0; i < 300 && !mux_ok; i++) w(1);
        chk("mux_ok", 1, mux_ok);
        if (!mux_ok) begin
            complete_run();
        end
        for (int i = 0; i < 8; i++) begin
            mux_sel <= i[2:0];
            mux_sel_wr <= 1;
            load_res_en <= i[0];
            w(1);
            mux_sel_wr <= 0;
            sk(1);
            chk("mux", (i == 7) ? 3'h6 : i[2:0], analog_select);
            chk("load_res", i[0], load_res_on);
            w(1);
        end
        debug_window_cmp <= 1;
        w(3);
        init_reset_exit <= 1;
        w(1);
        init_reset_exit <= 0;
        sk(3);
        chk("dbg", 2'b10, {debug_mode, watchdog_en});
        w(1);
        debug_exit_wr <= 1;
        w(1);
        debug_exit_wr <= 0;
        sk(2);
        chk("dbg", 2'b01, {debug_mode, watchdog_en});
        w(1);
        debug_window_cmp <= 0;
        for (int i = 0; i < 4; i++) begin
            r = rnd();
            safe_res_code <= r[1:0];
            safe_ovr_code <= r[3:2];
            safe_ovr_en <= r[4];
            sk(2);
            es = exp_safe(r[4], r[3:2], r[1:0]);
            chk("safe", es, safe_mode_code);
            w(1);
        end
        // set and clear together: the fault has to win
        fault_event <= 1;
        flag_clr <= 1;
        w(1);
        fault_event <= 0;
        flag_clr <= 0;
        sk(1);
        chk("safe_n", 0, fail_safe_out_n);
        w(1);
        line_stuck <= 1;
        sk(RST_SENSE_CYC / 2);
        chk("rst_fault", 0, reset_line_fault);
        sk(RST_SENSE_CYC / 2 + 8);
        chk("rst_fault", 1, reset_line_fault);
        // second reset: debug entered again, then left by the window
        w(1);
        reset_n <= 0;
        line_stuck <= 0;
        debug_window_cmp <= 1;
        w(2);
        reset_n <= 1;
        sk(2);
        chk("rst2", 4'b0101, {reset_line_fault, fail_safe_out_n,
            debug_mode, watchdog_en});
        w(1);
        safe_ovr_en <= 0;
        safe_res_code <= 2'h1;
        init_reset_exit <= 1;
        w(1);
        init_reset_exit <= 0;
        safe_res_code <= 2'h2;
        sk(2);
        chk("dbg_safe", 3'b101, {debug_mode, safe_mode_code});
        w(1);
        debug_window_cmp <= 0;
        sk(4);
        chk("dbg_win", 4'b0110, {debug_mode, watchdog_en,
            safe_mode_code});
        complete_run();
    end
endmodule
`default_nettype wire
